// file: charger_mode_pkg.sv
// Constants and types for the charger spec-info and mode command bank
package charger_mode_pkg;
    localparam logic [6:0] SLAVE_ADDR = 7'h12;
    localparam logic [7:0] CMD_SPEC_INFO = 8'h11;
    localparam logic [7:0] CMD_MODE_CTRL = 8'h12;
    localparam logic [15:0] SPEC_INFO_WORD = 16'h0009;
    localparam logic [15:0] VOLT_POR = 16'hFFFF;
    localparam logic [15:0] CURR_POR = 16'h00C0;
    localparam logic OVERTEMP_STOP_ENABLE_POR = 1'b1;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam int MODE_INHIBIT = 0;
    localparam int MODE_POR_RESET = 2;
    localparam int MODE_SRC_MASK = 4;
    localparam int MODE_BAT_MASK = 5;
    localparam int MODE_PF_MASK = 6;
    localparam int MODE_OVERTEMP_STOP_ENABLE = 10;
    localparam int PIN_SRC = 3;
    localparam int PIN_BAT = 2;
    localparam int PIN_PF = 1;
    localparam int PIN_HOT = 0;
    typedef enum logic [3:0] {
        PH_IDLE,
        PH_ADDR,
        PH_CMD,
        PH_WLO,
        PH_WHI,
        PH_ACK,
        PH_RLO,
        PH_RHI,
        PH_MACK,
        PH_SKIP
    } link_phase_type;
endpackage : charger_mode_pkg

// file: sync_2ff.sv
// Two-flop synchroniser for signals entering a clock domain
`timescale 1ns/1ps
module sync_2ff #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Data
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] q;
    } sync_state_type;

    sync_state_type s_reg;
    sync_state_type s_next;

    // First stage feeds only the second stage
    always_comb
    begin
        s_next.meta = i_d;
        s_next.q = s_reg.meta;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            s_reg <= {RST_VAL, RST_VAL};
        else
            s_reg <= s_next;
    end

    assign o_q = s_reg.q;
endmodule : sync_2ff

// file: charger_mode_bank.sv
// Charger spec-info and mode command bank with its two-wire bus slave
`timescale 1ns/1ps
module charger_mode_bank
    import charger_mode_pkg::*;
(
    // System clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Two-wire management bus
    input wire logic i_link_clk,
    input wire logic i_scl,
    input wire logic i_sda_in,
    output logic o_sda_out,
    output logic o_sda_drive_n,
    // Status inputs
    input wire logic i_source_detected,
    input wire logic i_battery_present,
    input wire logic i_power_fail,
    input wire logic i_overtemp_detect,
    input wire logic i_alarm_inhibit_set,
    // Charger state
    output logic o_charge_enable,
    output logic o_charge_inhibited,
    output logic o_overtemp_latch,
    output logic o_overtemp_stop_enable,
    output logic o_alarm_inhibit,
    output logic o_status_irq,
    output logic [15:0] o_target_voltage,
    output logic [15:0] o_target_current
);
    typedef struct packed {
        link_phase_type ph;
        link_phase_type nxt;
        logic [3:0] bits;
        logic [7:0] sh;
        logic [7:0] cmd;
        logic [7:0] lo;
        logic rd_hi;
        logic scl_d;
        logic sda_d;
        logic sda_o;
        logic drv_n;
        logic wr_tgl;
        logic [15:0] wr_data;
    } link_state_type;

    typedef struct packed {
        logic inhibit;
        logic src_mask;
        logic bat_mask;
        logic pf_mask;
        logic overtemp_stop_enable;
        logic overtemp;
        logic alarm;
        logic [2:0] stat_prev;
        logic wr_seen;
        logic irq;
        logic chg_en;
        logic [15:0] tgt_v;
        logic [15:0] tgt_i;
    } sys_state_type;

    localparam link_state_type LINK_RESET = '{
        ph: PH_IDLE, nxt: PH_IDLE, bits: 4'h0, sh: 8'h00, cmd: 8'h00,
        lo: 8'h00, rd_hi: 1'b0, scl_d: 1'b1, sda_d: 1'b1, sda_o: 1'b0,
        drv_n: 1'b1, wr_tgl: 1'b0, wr_data: 16'h0000};

    localparam sys_state_type SYS_RESET = '{
        inhibit: 1'b0, src_mask: 1'b0, bat_mask: 1'b0, pf_mask: 1'b0,
        overtemp_stop_enable: OVERTEMP_STOP_ENABLE_POR, overtemp: 1'b0, alarm: 1'b0,
        stat_prev: 3'h0, wr_seen: 1'b0, irq: 1'b0, chg_en: 1'b0,
        tgt_v: VOLT_POR, tgt_i: CURR_POR};

    function automatic logic [7:0] spec_byte(input logic hi);
        spec_byte = hi ? SPEC_INFO_WORD[15:8] : SPEC_INFO_WORD[7:0];
    endfunction : spec_byte

    link_state_type link_reg;
    link_state_type link_next;
    sys_state_type sys_reg;
    sys_state_type sys_next;

    logic link_rst;
    logic [1:0] bus_s;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic [7:0] rd_byte;
    logic [3:0] pin_s;
    logic wr_tgl_s;
    logic wr_evt;
    logic [15:0] mode_wd;
    logic [2:0] stat_now;
    logic [2:0] stat_mask;

    // Link-side reset follows the system reset into the bus clock
    sync_2ff #(.WIDTH(1), .RST_VAL(1'b1)) u_link_rst (
        .i_clk(i_link_clk),
        .i_rst(1'b0),
        .i_d(i_rst),
        .o_q(link_rst)
    );

    // Bus lines idle high, so they reset high
    sync_2ff #(.WIDTH(2), .RST_VAL(2'h3)) u_bus_sync (
        .i_clk(i_link_clk),
        .i_rst(link_rst),
        .i_d({i_scl, i_sda_in}),
        .o_q(bus_s)
    );

    sync_2ff #(.WIDTH(4), .RST_VAL(4'h0)) u_pin_sync (
        .i_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_d({i_source_detected, i_battery_present, i_power_fail, i_overtemp_detect}),
        .o_q(pin_s)
    );

    sync_2ff #(.WIDTH(1), .RST_VAL(1'b0)) u_wr_sync (
        .i_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_d(link_reg.wr_tgl),
        .o_q(wr_tgl_s)
    );

    assign scl = bus_s[1];
    assign sda = bus_s[0];
    assign scl_rise = scl & ~link_reg.scl_d;
    assign scl_fall = ~scl & link_reg.scl_d;
    assign bus_start = scl & link_reg.scl_d & link_reg.sda_d & ~sda;
    assign bus_stop = scl & link_reg.scl_d & ~link_reg.sda_d & sda;
    assign rd_byte = spec_byte(link_reg.nxt == PH_RHI);

    // Bus slave, oversampled on the link clock
    always_comb
    begin
        link_next = link_reg;
        link_next.scl_d = scl;
        link_next.sda_d = sda;
        if (bus_start)
        begin
            link_next.ph = PH_ADDR;
            link_next.bits = 4'h0;
            link_next.drv_n = 1'b1;
        end
        else if (bus_stop)
        begin
            link_next.ph = PH_IDLE;
            link_next.drv_n = 1'b1;
        end
        else
        begin
            case (link_reg.ph)
                PH_ADDR, PH_CMD, PH_WLO, PH_WHI:
                begin
                    if (scl_rise && link_reg.bits != BYTE_BITS)
                    begin
                        link_next.sh = {link_reg.sh[6:0], sda};
                        link_next.bits = link_reg.bits + 4'h1;
                    end
                    else if (scl_fall && link_reg.bits == BYTE_BITS)
                    begin
                        link_next.bits = 4'h0;
                        link_next.ph = PH_SKIP;
                        case (link_reg.ph)
                            PH_ADDR:
                            begin
                                // Reads only make sense after a spec-info command byte
                                if (link_reg.sh[7:1] == SLAVE_ADDR
                                    && (!link_reg.sh[0] || link_reg.cmd == CMD_SPEC_INFO))
                                begin
                                    link_next.ph = PH_ACK;
                                    link_next.nxt = link_reg.sh[0] ? PH_RLO : PH_CMD;
                                end
                            end
                            PH_CMD:
                            begin
                                link_next.cmd = link_reg.sh;
                                if (link_reg.sh == CMD_SPEC_INFO || link_reg.sh == CMD_MODE_CTRL)
                                begin
                                    link_next.ph = PH_ACK;
                                    link_next.nxt = PH_WLO;
                                end
                            end
                            PH_WLO:
                            begin
                                link_next.lo = link_reg.sh;
                                if (link_reg.cmd == CMD_MODE_CTRL)
                                begin
                                    link_next.ph = PH_ACK;
                                    link_next.nxt = PH_WHI;
                                end
                            end
                            default:
                            begin
                                // Word held stable until the next write, long after sampling
                                link_next.wr_data = {link_reg.sh, link_reg.lo};
                                link_next.wr_tgl = ~link_reg.wr_tgl;
                                link_next.ph = PH_ACK;
                                link_next.nxt = PH_SKIP;
                            end
                        endcase
                        link_next.drv_n = (link_next.ph != PH_ACK);
                    end
                end
                PH_ACK:
                begin
                    if (scl_fall)
                    begin
                        link_next.ph = link_reg.nxt;
                        link_next.drv_n = 1'b1;
                        if (link_reg.nxt == PH_RLO || link_reg.nxt == PH_RHI)
                        begin
                            link_next.drv_n = rd_byte[7];
                            link_next.sh = {rd_byte[6:0], 1'b0};
                            link_next.bits = 4'h1;
                        end
                    end
                end
                PH_RLO, PH_RHI:
                begin
                    if (scl_fall)
                    begin
                        if (link_reg.bits == BYTE_BITS)
                        begin
                            link_next.drv_n = 1'b1;
                            link_next.rd_hi = (link_reg.ph == PH_RHI);
                            link_next.ph = PH_MACK;
                        end
                        else
                        begin
                            link_next.drv_n = link_reg.sh[7];
                            link_next.sh = {link_reg.sh[6:0], 1'b0};
                            link_next.bits = link_reg.bits + 4'h1;
                        end
                    end
                end
                PH_MACK:
                begin
                    if (scl_rise)
                    begin
                        link_next.ph = PH_SKIP;
                        if (!sda && !link_reg.rd_hi)
                        begin
                            link_next.ph = PH_ACK;
                            link_next.nxt = PH_RHI;
                        end
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge i_link_clk)
    begin
        if (link_rst)
            link_reg <= LINK_RESET;
        else
            link_reg <= link_next;
    end

    assign o_sda_out = link_reg.sda_o;
    assign o_sda_drive_n = link_reg.drv_n;

    // Mode word and latches on the system clock
    assign wr_evt = wr_tgl_s != sys_reg.wr_seen;
    assign mode_wd = link_reg.wr_data;
    assign stat_now = pin_s[PIN_SRC:PIN_PF];
    assign stat_mask = {sys_reg.src_mask, sys_reg.bat_mask, sys_reg.pf_mask};

    always_comb
    begin
        sys_next = sys_reg;
        sys_next.wr_seen = wr_tgl_s;
        sys_next.stat_prev = stat_now;
        sys_next.irq = |((stat_now ^ sys_reg.stat_prev) & ~stat_mask);
        if (wr_evt)
        begin
            // Unlisted mode bits are simply not decoded
            sys_next.inhibit = mode_wd[MODE_INHIBIT];
            sys_next.src_mask = mode_wd[MODE_SRC_MASK];
            sys_next.bat_mask = mode_wd[MODE_BAT_MASK];
            sys_next.pf_mask = mode_wd[MODE_PF_MASK];
            sys_next.overtemp_stop_enable = mode_wd[MODE_OVERTEMP_STOP_ENABLE];
            if (mode_wd[MODE_POR_RESET])
            begin
                sys_next.tgt_v = VOLT_POR;
                sys_next.tgt_i = CURR_POR;
                sys_next.overtemp = 1'b0;
                sys_next.alarm = 1'b0;
            end
        end
        if (!pin_s[PIN_BAT])
        begin
            sys_next.overtemp = 1'b0;
            sys_next.alarm = 1'b0;
            sys_next.overtemp_stop_enable = OVERTEMP_STOP_ENABLE_POR;
        end
        // Set beats clear so a coincident event is never lost
        if (pin_s[PIN_HOT])
            sys_next.overtemp = 1'b1;
        if (i_alarm_inhibit_set)
            sys_next.alarm = 1'b1;
        sys_next.chg_en = ~sys_next.inhibit & ~(sys_next.overtemp & sys_next.overtemp_stop_enable);
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
            sys_reg <= SYS_RESET;
        else
            sys_reg <= sys_next;
    end

    assign o_charge_enable = sys_reg.chg_en;
    assign o_charge_inhibited = sys_reg.inhibit;
    assign o_overtemp_latch = sys_reg.overtemp;
    assign o_overtemp_stop_enable = sys_reg.overtemp_stop_enable;
    assign o_alarm_inhibit = sys_reg.alarm;
    assign o_status_irq = sys_reg.irq;
    assign o_target_voltage = sys_reg.tgt_v;
    assign o_target_current = sys_reg.tgt_i;

    sequence s_mode_wr;
        wr_evt;
    endsequence

    sequence s_addr_done;
        link_reg.ph == PH_ADDR && scl_fall && link_reg.bits == BYTE_BITS;
    endsequence

    property p_spec_bit0;
        @(posedge i_link_clk) disable iff (link_rst)
        (link_reg.ph == PH_RLO && link_reg.bits == BYTE_BITS) |-> link_reg.drv_n == SPEC_INFO_WORD[0];
    endproperty
    a_spec_bit0: assert property (p_spec_bit0) else $error("spec bit 0 wrong");

    property p_spec_high;
        @(posedge i_link_clk) disable iff (link_rst)
        (link_reg.ph == PH_RHI) |-> !link_reg.drv_n;
    endproperty
    a_spec_high: assert property (p_spec_high) else $error("spec high byte not zero");

    property p_addr_miss;
        @(posedge i_link_clk) disable iff (link_rst)
        (s_addr_done and (link_reg.sh[7:1] != SLAVE_ADDR)) |=> (link_reg.ph == PH_SKIP && link_reg.drv_n);
    endproperty
    a_addr_miss: assert property (p_addr_miss) else $error("foreign address acked");

    property p_inhibit_wr;
        @(posedge i_ref_clk) disable iff (i_rst)
        s_mode_wr |=> (o_charge_inhibited == $past(mode_wd[MODE_INHIBIT])) ##1 o_charge_enable == 1'b0
            || !o_charge_inhibited || wr_evt;
    endproperty
    a_inhibit_wr: assert property (p_inhibit_wr) else $error("inhibit not taken");

    property p_inhibit_hold;
        @(posedge i_ref_clk) disable iff (i_rst)
        !wr_evt |=> $stable(o_charge_inhibited);
    endproperty
    a_inhibit_hold: assert property (p_inhibit_hold) else $error("inhibit moved");

    property p_por_bit;
        @(posedge i_ref_clk) disable iff (i_rst)
        (s_mode_wr and mode_wd[MODE_POR_RESET]) |=> (o_target_voltage == VOLT_POR && o_target_current == CURR_POR);
    endproperty
    a_por_bit: assert property (p_por_bit) else $error("defaults not loaded");

    property p_irq;
        @(posedge i_ref_clk) disable iff (i_rst)
        ##1 (o_status_irq == $past(|((stat_now ^ sys_reg.stat_prev) & ~stat_mask)));
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");

    property p_overtemp_stop_enable;
        @(posedge i_ref_clk) disable iff (i_rst)
        (o_overtemp_latch && o_overtemp_stop_enable) |-> !o_charge_enable;
    endproperty
    a_overtemp_stop_enable: assert property (p_overtemp_stop_enable) else $error("hot battery charging");

    property p_hot_clear;
        @(posedge i_ref_clk) disable iff (i_rst)
        (!pin_s[PIN_BAT] && !pin_s[PIN_HOT]) |=> (!o_overtemp_latch && o_overtemp_stop_enable);
    endproperty
    a_hot_clear: assert property (p_hot_clear) else $error("removal not honoured");

    property p_power_up;
        @(posedge i_ref_clk)
        $past(i_rst) && !i_rst |-> (o_overtemp_stop_enable && !o_charge_inhibited && stat_mask == 3'h0);
    endproperty
    a_power_up: assert property (p_power_up) else $error("bad power-up state");
endmodule : charger_mode_bank

// file: smbus_host_model.sv
// Bus master model for the charger bank's two-wire port
`timescale 1ns/1ps
module smbus_host_model (
    // Oversampling clock
    input wire logic i_link_clk,
    // Wire levels
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    // Quarter bit in link clocks; slow enough for the 3-clock sync lag
    localparam int QTR = 8;
    initial
    begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    task automatic wait_q(input int n);
        repeat (n * QTR) @(posedge i_link_clk);
    endtask : wait_q
    // Data changes only while the clock is low
    task automatic bit_cycle(input logic b, output logic s);
        o_sda_low <= !b;
        wait_q(1);
        o_scl <= 1'b1;
        wait_q(1);
        s = i_sda;
        wait_q(1);
        o_scl <= 1'b0;
        wait_q(1);
    endtask : bit_cycle
    // Also serves as repeated start
    task automatic start_cond();
        o_sda_low <= 1'b0;
        wait_q(1);
        o_scl <= 1'b1;
        wait_q(1);
        o_sda_low <= 1'b1;
        wait_q(1);
        o_scl <= 1'b0;
        wait_q(1);
    endtask : start_cond
    task automatic stop_cond();
        o_sda_low <= 1'b1;
        wait_q(1);
        o_scl <= 1'b1;
        wait_q(1);
        o_sda_low <= 1'b0;
        wait_q(2);
    endtask : stop_cond
    task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ak);
        for (int i = 7; i >= 0; i--)
        begin
            bit_cycle(tx[i], rx[i]);
        end
        bit_cycle(mack, ak);
    endtask : xfer
    // Write-word frame; ak bits are 0 where acknowledged
    task automatic write_word(input logic [6:0] adr, input logic [7:0] cmd, input logic [15:0] d,
                              output logic [3:0] ak);
        logic [7:0] rx;
        start_cond();
        xfer({adr, 1'b0}, 1'b1, rx, ak[3]);
        xfer(cmd, 1'b1, rx, ak[2]);
        xfer(d[7:0], 1'b1, rx, ak[1]);
        xfer(d[15:8], 1'b1, rx, ak[0]);
        stop_cond();
    endtask : write_word
    // Read-word frame: low byte acked, high byte refused by the master
    task automatic read_word(input logic [6:0] adr, input logic [7:0] cmd, output logic [15:0] d,
                             output logic [2:0] ak);
        logic [7:0] rx;
        logic dummy;
        start_cond();
        xfer({adr, 1'b0}, 1'b1, rx, ak[2]);
        xfer(cmd, 1'b1, rx, ak[1]);
        start_cond();
        xfer({adr, 1'b1}, 1'b1, rx, ak[0]);
        xfer(8'hFF, 1'b0, d[7:0], dummy);
        xfer(8'hFF, 1'b1, d[15:8], dummy);
        stop_cond();
    endtask : read_word
endmodule : smbus_host_model

// file: charger_mode_bank_bench.sv
// Self-checking bench for the charger spec-info and mode bank
`timescale 1ns/1ps
module charger_mode_bank_bench;
    import charger_mode_pkg::*;
    logic i_ref_clk;
    logic i_link_clk;
    logic i_rst;
    logic scl;
    logic sda_low;
    logic sda_wire;
    logic sda_out;
    logic drive_n;
    logic [3:0] stat;
    logic alarm_set;
    logic chg_en;
    logic inhib;
    logic hot;
    logic stop_en;
    logic alarm;
    logic irq;
    logic [15:0] volt;
    logic [15:0] curr;
    int err_total;
    int checks;
    // Pull-up wire: low if either side pulls
    assign sda_wire = !(sda_low || (!drive_n && !sda_out));
    charger_mode_bank i_charger_mode_bank (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_link_clk(i_link_clk), .i_scl(scl),
        .i_sda_in(sda_wire), .o_sda_out(sda_out), .o_sda_drive_n(drive_n),
        .i_source_detected(stat[PIN_SRC]), .i_battery_present(stat[PIN_BAT]),
        .i_power_fail(stat[PIN_PF]), .i_overtemp_detect(stat[PIN_HOT]),
        .i_alarm_inhibit_set(alarm_set), .o_charge_enable(chg_en), .o_charge_inhibited(inhib),
        .o_overtemp_latch(hot), .o_overtemp_stop_enable(stop_en), .o_alarm_inhibit(alarm),
        .o_status_irq(irq), .o_target_voltage(volt), .o_target_current(curr)
    );
    smbus_host_model i_smbus_host_model (
        .i_link_clk(i_link_clk), .i_sda(sda_wire), .o_scl(scl), .o_sda_low(sda_low)
    );
    initial
    begin
        i_ref_clk = 1'b0;
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end
    // Unrelated phase to the system clock
    initial
    begin
        i_link_clk = 1'b0;
        #3.7;
        forever #7.5 i_link_clk = ~i_link_clk;
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic settle(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : settle
    task automatic mode_wr(input logic [15:0] d);
        logic [3:0] ak;
        i_smbus_host_model.write_word(SLAVE_ADDR, CMD_MODE_CTRL, d, ak);
        chk(16'(ak), 16'h0000);
        settle(10);
    endtask : mode_wr
    // Drives one status pin and counts interrupt pulses after it
    task automatic pin_irqs(input int idx, input logic v, output int n);
        @(posedge i_ref_clk);
        stat[idx] <= v;
        n = 0;
        repeat (12)
        begin
            @(posedge i_ref_clk);
            #1;
            n += int'(irq === 1'b1);
        end
    endtask : pin_irqs
    task automatic t_reset();
        chk(16'(inhib), 16'h0000);
        chk(16'(stop_en), 16'h0001);
        chk(volt, VOLT_POR);
        chk(curr, CURR_POR);
        chk(16'(drive_n), 16'h0001);
        chk(16'(sda_out), 16'h0000);
        chk(16'(irq), 16'h0000);
        chk(16'(chg_en), 16'h0001);
        $display("test reset done");
    endtask : t_reset
    task automatic t_spec();
        logic [15:0] d;
        logic [2:0] ak;
        i_smbus_host_model.read_word(SLAVE_ADDR, CMD_SPEC_INFO, d, ak);
        chk(16'(ak), 16'h0000);
        chk({12'h000, d[3:0]}, 16'h0009);
        chk({4'h0, d[15:4]}, 16'h0000);
        $display("test spec done");
    endtask : t_spec
    task automatic t_inhibit();
        mode_wr(16'h0001);
        chk(16'(inhib), 16'h0001);
        chk(16'(chg_en), 16'h0000);
        mode_wr(16'h0000);
        chk(16'(inhib), 16'h0000);
        chk(16'(chg_en), 16'h0001);
        $display("test inhibit done");
    endtask : t_inhibit
    // Refused frames must leave the inhibit latch alone
    task automatic t_refuse();
        logic [3:0] ak;
        mode_wr(16'h0001);
        i_smbus_host_model.write_word(7'h13, CMD_MODE_CTRL, 16'h0000, ak);
        chk(16'(ak), 16'h000F);
        i_smbus_host_model.write_word(SLAVE_ADDR, CMD_SPEC_INFO, 16'h0000, ak);
        chk(16'(ak), 16'h0003);
        i_smbus_host_model.write_word(SLAVE_ADDR, 8'h13, 16'h0000, ak);
        chk(16'(ak), 16'h0007);
        settle(10);
        chk(16'(inhib), 16'h0001);
        mode_wr(16'h0000);
        $display("test refuse done");
    endtask : t_refuse
    task automatic t_irq();
        int pins[3];
        int n;
        pins = '{PIN_SRC, PIN_BAT, PIN_PF};
        for (int k = 0; k < 3; k++)
        begin
            pin_irqs(pins[k], 1'b1, n);
            chk(16'(n), 16'h0001);
            pin_irqs(pins[k], 1'b0, n);
            chk(16'(n), 16'h0001);
            mode_wr(16'h0400 | (16'h0001 << (MODE_SRC_MASK + k)));
            pin_irqs(pins[k], 1'b1, n);
            chk(16'(n), 16'h0000);
            pin_irqs(pins[k], 1'b0, n);
            chk(16'(n), 16'h0000);
            mode_wr(16'h0400);
        end
        $display("test irq done");
    endtask : t_irq
    task automatic t_hot();
        int n;
        pin_irqs(PIN_BAT, 1'b1, n);
        pin_irqs(PIN_HOT, 1'b1, n);
        pin_irqs(PIN_HOT, 1'b0, n);
        chk(16'(hot), 16'h0001);
        chk(16'(chg_en), 16'h0000);
        mode_wr(16'h0000);
        chk(16'(chg_en), 16'h0001);
        @(posedge i_ref_clk);
        alarm_set <= 1'b1;
        @(posedge i_ref_clk);
        alarm_set <= 1'b0;
        settle(4);
        chk(16'(alarm), 16'h0001);
        mode_wr(16'h0004);
        chk(16'(hot), 16'h0000);
        chk(16'(alarm), 16'h0000);
        chk(volt, VOLT_POR);
        chk(curr, CURR_POR);
        pin_irqs(PIN_HOT, 1'b1, n);
        pin_irqs(PIN_HOT, 1'b0, n);
        pin_irqs(PIN_BAT, 1'b0, n);
        chk(16'(hot), 16'h0000);
        chk(16'(stop_en), 16'h0001);
        // Battery back first, or removal would hold the stop enable at one
        pin_irqs(PIN_BAT, 1'b1, n);
        chk(16'(n), 16'h0001);
        // Only meaningless bits set: nothing but bit 10 clearing shows
        mode_wr(16'hFB8A);
        chk(16'(inhib), 16'h0000);
        chk(16'(stop_en), 16'h0000);
        pin_irqs(PIN_SRC, 1'b1, n);
        chk(16'(n), 16'h0001);
        $display("test overtemp done");
    endtask : t_hot
    task automatic report_and_stop();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
        begin
            $display("Run complete: PASS");
        end
        else
        begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    initial
    begin
        err_total = 0;
        checks = 0;
        i_rst = 1'b1;
        stat = 4'h0;
        alarm_set = 1'b0;
        repeat (4) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        settle(8);
        t_reset();
        t_spec();
        t_inhibit();
        t_refuse();
        t_irq();
        t_hot();
        report_and_stop();
    end
endmodule : charger_mode_bank_bench
